// file: hw/scfd_top.sv
module scfd_top
  import scfd_pkg::*;
#(
  parameter int IO_PINS = 4,
  parameter logic [7:0] DEVICE_ID = 8'h50 // arbitrary identity value
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  // device state reported on the link
  input wire logic [7:0] i_fixed_status,
  input wire logic [7:0] i_ext_status,
  input wire logic [FLAG_REGS*8-1:0] i_dev_flags,
  input wire logic [FLAG_REGS*8-1:0] i_wake_flags,
  input wire logic [IO_PINS-1:0] i_io_pins,
  // supply and mode state
  input wire logic i_can_reg_on,
  input wire logic i_normal_mode,
  // analog multiplexer control
  output logic [2:0] o_source_select,
  output logic [6:0] o_analog_route,
  output logic o_analog_output_en,
  output logic o_internal_load_resistor_enable,
  output logic o_io_attenuate,
  // configuration and frame status
  output logic [7:0] o_misc_init,
  output logic o_parity_enable,
  output logic o_parity_error,
  output logic o_frame_done
);

  // =====================================================================
  // reset release
  logic rst_s1_reg;
  logic rst_b_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_b_reg <= rst_s1_reg;
    end
  end

  // =====================================================================
  // link side
  scfd_xfer_if xfer ();

  scfd_link u_link (
    .i_sclk(i_sclk),
    .i_cs_b(i_cs_b),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .i_rst_b(rst_b_reg),
    .x(xfer.link)
  );

  // =====================================================================
  // crossings into the core clock
  logic [2:0] link_sync;
  logic [IO_PINS-1:0] io_sync;
  logic cs_idle;
  logic tgl_sync;
  logic ovr_sync;

  scfd_sync #(
    .WIDTH(3)
  ) u_link_sync (
    .i_clk(i_clk),
    .i_rst_b(rst_b_reg),
    .i_async({~i_cs_b, xfer.frame_tgl, xfer.overrun}),
    .o_sync(link_sync)
  );

  scfd_sync #(
    .WIDTH(IO_PINS)
  ) u_io_sync (
    .i_clk(i_clk),
    .i_rst_b(rst_b_reg),
    .i_async(i_io_pins),
    .o_sync(io_sync)
  );

  assign cs_idle = ~link_sync[2];
  assign tgl_sync = link_sync[1];
  assign ovr_sync = link_sync[0];

  // =====================================================================
  // frame acceptance at the end of chip select
  logic cs_idle_reg;
  logic tgl_seen_reg;
  logic exec_next;
  logic [15:0] word;
  scfd_cmd_t cmd;
  logic [4:0] addr;
  logic parity_ok;
  logic analog_allowed;

  assign exec_next = cs_idle && !cs_idle_reg && (tgl_sync != tgl_seen_reg) && !ovr_sync;
  assign word = xfer.frame_word;
  assign cmd = scfd_cmd_t'(word[CMD_MSB:CMD_LSB]);
  assign addr = word[ADDR_MSB:ADDR_LSB];
  // checked only for writes, only when enabled
  assign parity_ok = !o_misc_init[MISC_PARITY_EN_POS] || frame_parity_ok(word);
  assign analog_allowed = i_can_reg_on && i_normal_mode;

  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      cs_idle_reg <= 1'b1;
      tgl_seen_reg <= 1'b0;
      o_frame_done <= 1'b0;
    end else begin
      cs_idle_reg <= cs_idle;
      if (cs_idle && !cs_idle_reg) begin
        tgl_seen_reg <= tgl_sync;
      end
      o_frame_done <= exec_next;
    end
  end

  // =====================================================================
  // analog select register
  logic [7:0] analog_select_reg;
  logic [7:0] analog_select_next;

  always_comb begin
    analog_select_next = analog_select_reg;
    if (!analog_allowed) begin
      analog_select_next = ANALOG_SELECT_RST;
    end else if (exec_next && cmd == SCFD_CMD_WRITE && addr == ADDR_ANALOG_SELECT
                 && parity_ok) begin
      analog_select_next = word[7:0] & ANALOG_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      analog_select_reg <= ANALOG_SELECT_RST;
    end else begin
      analog_select_reg <= analog_select_next;
    end
  end

  // =====================================================================
  // miscellaneous init register
  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_misc_init <= MISC_INIT_RST;
      o_parity_enable <= 1'b0;
    end else begin
      if (exec_next && cmd == SCFD_CMD_WRITE && addr == ADDR_MISC_INIT && parity_ok) begin
        o_misc_init <= word[7:0];
        o_parity_enable <= word[MISC_PARITY_EN_POS];
      end
    end
  end

  // =====================================================================
  // parity error flag: set by a failing write, cleared by a passing one
  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_parity_error <= 1'b0;
    end else if (exec_next && cmd == SCFD_CMD_WRITE) begin
      o_parity_error <= !parity_ok;
    end
  end

  // =====================================================================
  // decoded multiplexer outputs
  logic [2:0] sel;
  logic [6:0] route;

  assign sel = analog_select_reg[SEL_MSB:SEL_LSB];

  always_comb begin
    route = 7'h00;
    if (sel != 3'h0) begin
      route[sel - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_source_select <= 3'h0;
      o_analog_route <= 7'h00;
      o_analog_output_en <= 1'b0;
      o_internal_load_resistor_enable <= 1'b0;
      o_io_attenuate <= 1'b0;
    end else begin
      o_source_select <= sel;
      o_analog_route <= route;
      o_analog_output_en <= sel != 3'h0;
      o_internal_load_resistor_enable <= analog_select_reg[LOAD_RES_POS];
      o_io_attenuate <= analog_select_reg[IO_ATT_POS]
                        && (sel == SEL_IO_FIRST || sel == SEL_IO_SECOND);
    end
  end

  // =====================================================================
  // reply bank: refreshed only between frames so the link reads stable words
  always_ff @(posedge i_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      xfer.fixed_status <= 8'h00;
      xfer.ext_status <= 8'h00;
      xfer.analog_select <= ANALOG_SELECT_RST;
      xfer.misc_init <= MISC_INIT_RST;
      xfer.id_io <= 8'h00;
      xfer.flags_lo <= '0;
      xfer.flags_hi <= '0;
    end else if (cs_idle) begin
      xfer.fixed_status <= i_fixed_status;
      xfer.ext_status <= i_ext_status;
      xfer.analog_select <= analog_select_next;
      xfer.misc_init <= o_misc_init;
      xfer.id_io <= {DEVICE_ID[7:IO_PINS], io_sync};
      xfer.flags_lo <= i_dev_flags;
      xfer.flags_hi <= i_wake_flags;
    end
  end

endmodule // scfd_top

// file: hw/scfd_pkg.sv
package scfd_pkg;

  // =====================================================================
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 14;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 9;
  localparam int PARITY_POS = 8;
  localparam int SUBADDR_POS = 7;
  localparam logic [4:0] BIT_LAST = 5'h0f;
  localparam logic [4:0] BIT_DATA = 5'h08;
  localparam logic [4:0] BIT_DONE = 5'h10;

  typedef enum logic [1:0] {
    SCFD_CMD_READ,
    SCFD_CMD_WRITE,
    SCFD_CMD_RSVD,
    SCFD_CMD_FLAGS
  } scfd_cmd_t;

  // =====================================================================
  // register map
  localparam logic [4:0] ADDR_ANALOG_SELECT = 5'h00;
  localparam logic [4:0] ADDR_MISC_INIT = 5'h08;
  localparam logic [4:0] ADDR_FLAG_BASE = 5'h10;
  localparam int FLAG_REGS = 4;
  localparam int MISC_PARITY_EN_POS = 6;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int LOAD_RES_POS = 4;
  localparam int IO_ATT_POS = 3;
  localparam logic [7:0] ANALOG_WRITE_MASK = 8'hf8;
  localparam logic [7:0] ANALOG_SELECT_RST = 8'h00;
  localparam logic [7:0] MISC_INIT_RST = 8'h00;
  localparam logic [2:0] SEL_IO_FIRST = 3'h4;
  localparam logic [2:0] SEL_IO_SECOND = 3'h5;

  // odd count of ones over the whole frame means the parity bit is right
  function automatic logic frame_parity_ok(input logic [15:0] w);
    return ^w;
  endfunction

endpackage

// file: hw/scfd_xfer_if.sv
interface scfd_xfer_if;
  import scfd_pkg::*;

  // link to core: captured frame and its markers
  logic [15:0] frame_word;
  logic frame_tgl;
  logic overrun;
  // core to link: reply bank, frozen while a frame is in progress
  logic [7:0] fixed_status;
  logic [7:0] ext_status;
  logic [7:0] analog_select;
  logic [7:0] misc_init;
  logic [7:0] id_io;
  logic [FLAG_REGS*8-1:0] flags_lo;
  logic [FLAG_REGS*8-1:0] flags_hi;

  modport link (
    output frame_word, frame_tgl, overrun,
    input fixed_status, ext_status, analog_select, misc_init, id_io, flags_lo, flags_hi
  );
  modport core (
    input frame_word, frame_tgl, overrun,
    output fixed_status, ext_status, analog_select, misc_init, id_io, flags_lo, flags_hi
  );
endinterface

// file: hw/scfd_sync.sv
module scfd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // async level in, filtered level out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // =====================================================================
  // three stages; a bit changes only when stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      o_sync <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          o_sync[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule // scfd_sync

// file: hw/scfd_link.sv
module scfd_link
  import scfd_pkg::*;
(
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  // core reset copy
  input wire logic i_rst_b,
  // crossing
  scfd_xfer_if.link x
);

  logic [4:0] count_reg;
  logic [14:0] rx_reg;
  logic [6:0] tx_reg;
  logic [15:0] full_word;
  logic [7:0] second_byte;

  assign full_word = {rx_reg, i_mosi};

  // second reply byte, picked at the first data bit with the live sub-address
  function automatic logic [7:0] reply_byte(input logic [1:0] cmd, input logic [4:0] addr,
                                            input logic sub);
    logic [7:0] r;
    logic [4:0] idx;
    r = 8'h00;
    idx = addr - ADDR_FLAG_BASE;
    unique case (scfd_cmd_t'(cmd))
      SCFD_CMD_READ: begin
        if (sub) begin
          r = x.id_io;
        end else if (addr == ADDR_ANALOG_SELECT) begin
          r = x.analog_select;
        end else if (addr == ADDR_MISC_INIT) begin
          r = x.misc_init;
        end
      end
      SCFD_CMD_WRITE: r = x.ext_status;
      SCFD_CMD_RSVD: r = 8'h00;
      SCFD_CMD_FLAGS: begin
        if (addr >= ADDR_FLAG_BASE && idx < 5'(FLAG_REGS)) begin
          r = sub ? x.flags_hi[idx[1:0]*8 +: 8] : x.flags_lo[idx[1:0]*8 +: 8];
        end
      end
    endcase
    return r;
  endfunction

  assign second_byte = reply_byte(rx_reg[7:6], rx_reg[5:1], i_mosi);

  // =====================================================================
  // bit counter, receive and transmit shifters; cleared by chip select
  always_ff @(posedge i_sclk or posedge i_cs_b) begin
    if (i_cs_b) begin
      count_reg <= 5'h00;
      rx_reg <= 15'h0000;
      tx_reg <= 7'h00;
      o_miso <= 1'b0;
    end else begin
      if (count_reg != BIT_DONE) begin
        count_reg <= count_reg + 5'h01;
      end
      rx_reg <= full_word[14:0];
      if (count_reg == 5'h00) begin
        o_miso <= x.fixed_status[7];
        tx_reg <= x.fixed_status[6:0];
      end else if (count_reg == BIT_DATA) begin
        o_miso <= second_byte[7];
        tx_reg <= second_byte[6:0];
      end else if (count_reg < BIT_DONE) begin
        o_miso <= tx_reg[6];
        tx_reg <= {tx_reg[5:0], 1'b0};
      end else begin
        o_miso <= 1'b0;
      end
    end
  end

  // =====================================================================
  // captured frame, marker toggle and overlength flag
  always_ff @(posedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      x.frame_word <= 16'h0000;
      x.frame_tgl <= 1'b0;
      x.overrun <= 1'b0;
    end else if (!i_cs_b) begin
      if (count_reg == BIT_LAST) begin
        x.frame_word <= full_word;
        x.frame_tgl <= ~x.frame_tgl;
      end
      if (count_reg == 5'h00) begin
        x.overrun <= 1'b0;
      end else if (count_reg == BIT_DONE) begin
        x.overrun <= 1'b1;
      end
    end
  end

endmodule // scfd_link

// file: verification/scfd_top_properties.sv
module scfd_top_properties (
  // clock, reset and watched inputs
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_can_reg_on,
  input wire logic i_normal_mode,
  // watched outputs
  input wire logic o_miso,
  input wire logic [2:0] o_source_select,
  input wire logic [6:0] o_analog_route,
  input wire logic o_analog_output_en,
  input wire logic o_internal_load_resistor_enable,
  input wire logic o_io_attenuate,
  input wire logic [7:0] o_misc_init,
  input wire logic o_parity_enable,
  input wire logic o_parity_error,
  input wire logic o_frame_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // ==========
  // sequences
  sequence s_mode_off;
    !(i_normal_mode && i_can_reg_on) [*2];
  endsequence

  // ==========
  // properties
  chk_route_decode: assert property (
    o_analog_route == (o_source_select == 3'h0 ? 7'h00 : 7'h01 << (o_source_select - 3'h1)))
    else $error("analog route does not match source select");
  chk_output_enable: assert property (
    o_analog_output_en == (o_source_select != 3'h0))
    else $error("output enable does not match source select");
  chk_mode_clear: assert property (
    s_mode_off |=> o_source_select == 3'h0 && !o_internal_load_resistor_enable && !o_io_attenuate)
    else $error("analog select not cleared outside normal mode");
  chk_select_cause: assert property (
    $changed(o_source_select) |-> $past(o_frame_done) || !$past(i_normal_mode) ||
      !$past(i_can_reg_on))
    else $error("source select changed without a frame");
  chk_done_single: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done longer than one cycle");
  chk_done_after_cs: assert property (
    o_frame_done |-> i_cs_b && $past(i_cs_b) && $past(i_cs_b, 2))
    else $error("frame done before chip select settled high");
  chk_parity_gate: assert property ($rose(o_parity_error) |-> o_parity_enable)
    else $error("parity error raised while parity disabled");
  chk_misc_parity: assert property (o_parity_enable == o_misc_init[6])
    else $error("parity enable does not follow init bit 6");
  chk_miso_idle: assert property (i_cs_b && $past(i_cs_b) |-> !o_miso)
    else $error("serial out active while deselected");
endmodule // scfd_top_properties

bind scfd_top scfd_top_properties i_scfd_top_properties (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
  .i_can_reg_on(i_can_reg_on), .i_normal_mode(i_normal_mode), .o_miso(o_miso),
  .o_source_select(o_source_select), .o_analog_route(o_analog_route),
  .o_analog_output_en(o_analog_output_en),
  .o_internal_load_resistor_enable(o_internal_load_resistor_enable),
  .o_io_attenuate(o_io_attenuate), .o_misc_init(o_misc_init),
  .o_parity_enable(o_parity_enable), .o_parity_error(o_parity_error),
  .o_frame_done(o_frame_done)
);

// file: verification/scfd_host_model.sv
module scfd_host_model (
  // serial link
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b1;
  end

  // one frame of n clocks, msb first; write frames get their parity bit here
  task automatic xfer(input logic [15:0] w, input bit par_on, input bit bad,
                      input int n, output logic [15:0] rx);
    logic [15:0] f;
    f = w;
    if (f[15:14] == 2'b01) f[8] = par_on ? ~^{f[15:9], f[7:0]} ^ bad : 1'b0;
    o_cs_b = 1'b0;
    #200;
    for (int k = 0; k < n; k++) begin
      o_mosi = f[15 - k];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
      rx[15 - k] = i_miso;
    end
    #3 o_mosi = ~o_mosi;
    o_cs_b = 1'b1;
    #240;
  endtask
endmodule // scfd_host_model

// file: verification/tb_top.sv
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("BAD %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b, sclk, cs_b, mosi, miso, can_on, normal;
  logic [7:0] fixed, ext, misc;
  logic [31:0] dflags, wflags;
  logic [3:0] io;
  logic [2:0] sel;
  logic [6:0] route;
  logic out_en, load, att, par_en, par_err, done;
  logic [15:0] rx;
  bit par_on;
  int fail_count, compares;

  always #20 clk = ~clk;

  scfd_top i_scfd_top (
    .i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_mosi(mosi),
    .o_miso(miso), .i_fixed_status(fixed), .i_ext_status(ext), .i_dev_flags(dflags),
    .i_wake_flags(wflags), .i_io_pins(io), .i_can_reg_on(can_on), .i_normal_mode(normal),
    .o_source_select(sel), .o_analog_route(route), .o_analog_output_en(out_en),
    .o_internal_load_resistor_enable(load), .o_io_attenuate(att), .o_misc_init(misc),
    .o_parity_enable(par_en), .o_parity_error(par_err), .o_frame_done(done)
  );
  scfd_host_model i_scfd_host_model (
    .o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso)
  );

  // ==========
  // access tasks
  task automatic frame(input logic [15:0] w, input bit bad = 1'b0, input int n = 16);
    i_scfd_host_model.xfer(w, par_on, bad, n, rx);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    frame({2'b01, a, 1'b0, d});
  endtask
  task automatic rd(input logic [4:0] a, input logic b7);
    frame({2'b00, a, 1'b1, b7, 7'h00});
  endtask
  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  // ==========
  // tests
  initial begin
    rst_b = 1'b0;
    can_on = 1'b1;
    normal = 1'b1;
    fixed = 8'hc3;
    ext = 8'h3c;
    dflags = 32'h44332211;
    wflags = 32'hddccbbaa;
    io = 4'ha;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("sel reset", 3'h0, sel)
    rd(5'h00, 1'b0);
    `CHK("select reset", 16'hc300, rx)
    wr(5'h00, 8'haf);
    `CHK("write reply", 16'hc33c, rx)
    `CHK("attenuate", 1'b1, att)
    `CHK("load off", 1'b0, load)
    rd(5'h00, 1'b0);
    `CHK("readback", 16'hc3a8, rx)
    for (int c = 0; c < 8; c++) begin
      wr(5'h00, {c[2:0], 5'h10});
      `CHK("route", c == 0 ? 7'h00 : 7'h01 << (c - 1), route)
      `CHK("out en", c != 0, out_en)
      `CHK("load on", 1'b1, load)
      if (c == 4) `CHK("gain", 1'b0, att)
    end
    rd(5'h00, 1'b1);
    `CHK("id io", 16'hc35a, rx)
    for (int b = 0; b < 2; b++) begin
      frame({2'b11, 5'h12, 1'b1, b[0], 7'h00});
      `CHK("flags", b ? 16'hc3cc : 16'hc333, rx)
    end
    wr(5'h08, 8'h40);
    `CHK("parity on", 1'b1, par_en)
    par_on = 1'b1;
    wr(5'h00, 8'h60);
    `CHK("good parity", 3'h3, sel)
    `CHK("no error", 1'b0, par_err)
    frame({2'b01, 5'h00, 1'b0, 8'h80}, 1'b1);
    `CHK("bad ignored", 3'h3, sel)
    `CHK("error", 1'b1, par_err)
    rd(5'h08, 1'b0);
    `CHK("read no parity", 16'hc340, rx)
    wr(5'h08, 8'h00);
    par_on = 1'b0;
    `CHK("parity off", 1'b0, par_en)
    normal = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("mode clear", 3'h0, sel)
    normal = 1'b1;
    can_on = 1'b0;
    wr(5'h00, 8'h20);
    `CHK("can off write", 3'h0, sel)
    rd(5'h00, 1'b0);
    `CHK("can off read", 16'hc300, rx)
    can_on = 1'b1;
    wr(5'h00, 8'h20);
    frame({2'b01, 5'h00, 1'b0, 8'hff}, 1'b0, 8);
    rd(5'h00, 1'b0);
    `CHK("short frame", 16'hc320, rx)
    report_and_stop();
  end
endmodule // tb_top
